// ===== shared/apd_regs.svh
// named constants of the auto power-down controller
// assumes inclusion by bare name from rtl and testbench files
`ifndef APD_REGS_SVH
`define APD_REGS_SVH

`define APD_CNT_ZERO        4'h0
`define APD_CNT_ONE         4'h1
`define APD_IDLE_LIMIT      4'hf

`define APD_REG_RESET       8'h00
`define APD_REGA_MASK       8'h3a
`define APD_REGB_MASK       8'h3c
`define APD_SEL_REG_A       1'b0
`define APD_SEL_REG_B       1'b1

`define APD_REGA_ENABLE     1
`define APD_REGA_TURBO      3
`define APD_REGA_ARRAY_CLK  4
`define APD_REGA_MCELL_CLK  5

`define APD_REGB_WR         2
`define APD_REGB_RD         3
`define APD_REGB_PSEN       4
`define APD_REGB_ALE        5

`define APD_NUM_PINS        8
`define APD_FUNC_W          2
`define APD_CTL_W           7
`define APD_BUS_W           24
// chip select and the write, read and psen strobes rest high, so memories start deselected
`define APD_CTL_RST         7'h3c
`define APD_BUS_RST         24'h000000
`define APD_ADDR_LSB        8
`define APD_ADDR_RST        16'h0000
`define APD_DATA_RST        8'h00
`define APD_PLD_RST         6'h07

`endif

// ===== shared/apd_pkg.sv
// types of the auto power-down controller
// assumes nothing beyond a SystemVerilog compiler
package apd_pkg;

  typedef enum logic {
    APD_RUN,
    APD_DOWN
  } apd_state_t;

  // order fixes the two-bit code given on the port function inputs
  typedef enum logic [1:0] {
    APD_PF_MCU_IO,
    APD_PF_PLD_OUT,
    APD_PF_ADDR_OUT,
    APD_PF_PERIPH
  } apd_port_func_t;

endpackage : apd_pkg

// ===== rtl/apd_sync.sv
// two-flop synchroniser for pin inputs
// assumes the inputs are asynchronous to clk
module apd_sync
  import apd_pkg::*;
#(
  parameter int               WIDTH   = 1,
  parameter logic [WIDTH-1:0] RST_VAL = '0
)
(
  input  wire logic             clk,
  input  wire logic             nrst,
  input  wire logic [WIDTH-1:0] asyncIn,
  output logic      [WIDTH-1:0] syncOut
);

  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] meta_d;
  logic [WIDTH-1:0] sync_q;
  logic [WIDTH-1:0] sync_d;

  always_comb
  begin
    meta_d = asyncIn;
    sync_d = meta_q;
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      meta_q <= RST_VAL;
      sync_q <= RST_VAL;
    end
    else
    begin
      meta_q <= meta_d;
      sync_q <= sync_d;
    end
  end

  assign syncOut = sync_q;

endmodule : apd_sync

// ===== rtl/apd_top.sv
// auto power-down controller: idle counter, bus blocking, memory selects,
// input blocking bits, turbo bit and port pin behaviour in power-down
// assumes nrst is the power-up reset; all pin inputs are asynchronous
//
// Summary of operation
// [R1] four-bit idle counter ticks per pin clock
// [R2] fifteen idle periods raise power-down output
// [R3] enable bit, with chip select high, allows power-down entry
// [R4] strobe activity wakes the device
// [R5] chip select low or reset high wakes
// [R6] power-down blocks bus, deselects memories
// [R7] clock masking never stops the counter
// [R8] logic and ports keep running in power-down
// [R9] pins hold, address undefined, peripheral tri-state
// [R10] blocking bits stop inputs reaching logic
// [R11] bit 3 set selects low-power logic
// [R12] host keeps clock 5MHz under maximum
// [R13] chip select high disables memories, io block
// [R14] chip select never blocks logic signals
// [R15] pin clock feeds macrocells and counter
// [R16] other savings only via two mode registers
// [R17] counts only enabled with steady strobe
// [R18] bit 1 of register a enables
// [R19] register b bits 2-5 block inputs
// [R20] mode registers clear at power-up only
// [R21] every strobe edge restarts idle count
`include "apd_regs.svh"
module apd_top
  import apd_pkg::*;
(
  input  wire logic                                  clk,
  input  wire logic                                  nrst,
  input  wire logic                                  addrStrobe,
  input  wire logic                                  pin_clock_in,
  input  wire logic                                  chipSelectN,
  input  wire logic                                  resetIn,
  input  wire logic                                  mcuWrN,
  input  wire logic                                  mcuRdN,
  input  wire logic                                  mcuPsenN,
  input  wire logic [15:0]                           mcuAddr,
  input  wire logic [7:0]                            mcuData,
  input  wire logic                                  regWrite,
  input  wire logic                                  regSelect,
  input  wire logic [7:0]                            regWdata,
  input  wire logic [`APD_NUM_PINS*`APD_FUNC_W-1:0]  portFunc,
  input  wire logic [`APD_NUM_PINS-1:0]              portDataOut,
  input  wire logic [`APD_NUM_PINS-1:0]              portDirOut,
  input  wire logic [`APD_NUM_PINS-1:0]              pldOut,
  input  wire logic [`APD_NUM_PINS-1:0]              pldOe,
  output logic                                       power_down_out,
  output logic      [15:0]                           busAddr,
  output logic      [7:0]                            busData,
  output logic                                       flashSelect,
  output logic                                       sramSelect,
  output logic                                       ioRegisterBlockSelect,
  output logic                                       pldWrN,
  output logic                                       pldRdN,
  output logic                                       pldPsenN,
  output logic                                       pldAle,
  output logic                                       pldArrayClk,
  output logic                                       pldMcellClk,
  output logic                                       turboOff,
  output logic      [7:0]                            power_mode_reg_a,
  output logic      [7:0]                            power_mode_reg_b,
  output logic      [3:0]                            idleCount,
  output logic      [`APD_NUM_PINS-1:0]              portOut,
  output logic      [`APD_NUM_PINS-1:0]              portOe
);

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers

  logic [`APD_CTL_W-1:0] ctlS;
  logic [`APD_BUS_W-1:0] busS;
  logic                  aleS;
  logic                  clkS;
  logic                  wrS;
  logic                  rdS;
  logic                  psenS;
  logic                  csnS;
  logic                  rstS;

  apd_sync #(.WIDTH(`APD_CTL_W), .RST_VAL(`APD_CTL_RST)) u_ctl_sync (
    .clk     (clk),
    .nrst    (nrst),
    .asyncIn ({resetIn, chipSelectN, mcuPsenN, mcuRdN, mcuWrN, pin_clock_in, addrStrobe}),
    .syncOut (ctlS)
  );

  // bus words are only sampled for forwarding, never compared bit against bit
  apd_sync #(.WIDTH(`APD_BUS_W), .RST_VAL(`APD_BUS_RST)) u_bus_sync (
    .clk     (clk),
    .nrst    (nrst),
    .asyncIn ({mcuAddr, mcuData}),
    .syncOut (busS)
  );

  assign {rstS, csnS, psenS, rdS, wrS, clkS, aleS} = ctlS;

  ////////////////////////////////////////////////////////////////////////////
  // mode registers

  logic [7:0] regA_q;
  logic [7:0] regA_d;
  logic [7:0] regB_q;
  logic [7:0] regB_d;

  // warm reset is not wired here so the bits survive it
  always_comb
  begin
    regA_d = regA_q;
    regB_d = regB_q;
    if (regWrite && regSelect == `APD_SEL_REG_A)
      regA_d = regWdata & `APD_REGA_MASK; // R16
    if (regWrite && regSelect == `APD_SEL_REG_B)
      regB_d = regWdata & `APD_REGB_MASK; // R16
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      regA_q <= `APD_REG_RESET; // R20
      regB_q <= `APD_REG_RESET; // R20
    end
    else
    begin
      regA_q <= regA_d;
      regB_q <= regB_d;
    end
  end

  logic apdEn;
  assign apdEn = regA_q[`APD_REGA_ENABLE]; // R18

  ////////////////////////////////////////////////////////////////////////////
  // idle counter and power-down state

  apd_state_t state_q;
  apd_state_t state_d;
  logic [3:0] cnt_q;
  logic [3:0] cnt_d;
  logic       aleLast_q;
  logic       clkLast_q;
  logic       aleEdge;
  logic       clkRise;
  logic       wake;

  assign aleEdge = aleS ^ aleLast_q;
  assign clkRise = clkS & ~clkLast_q;
  assign wake    = aleEdge | ~csnS | rstS;

  always_comb
  begin
    state_d = state_q;
    cnt_d   = cnt_q;
    case (state_q)
      APD_RUN:
      begin
        if (!apdEn || aleEdge || rstS)
          cnt_d = `APD_CNT_ZERO; // R17 R21
        else if (clkRise && cnt_q != `APD_IDLE_LIMIT)
          cnt_d = cnt_q + `APD_CNT_ONE; // R1 R7 R15
        // entry waits while selected, else it would wake at once
        if (apdEn && cnt_q == `APD_IDLE_LIMIT && csnS && !aleEdge && !rstS)
          state_d = APD_DOWN; // R2 R3
      end
      APD_DOWN:
      begin
        if (wake || !apdEn)
        begin
          state_d = APD_RUN; // R4 R5
          cnt_d   = `APD_CNT_ZERO;
        end
      end
      default:
      begin
        state_d = APD_RUN;
        cnt_d   = `APD_CNT_ZERO;
      end
    endcase
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      state_q   <= APD_RUN;
      cnt_q     <= `APD_CNT_ZERO;
      aleLast_q <= 1'b0;
      clkLast_q <= 1'b0;
    end
    else
    begin
      state_q   <= state_d;
      cnt_q     <= cnt_d;
      aleLast_q <= aleS;
      clkLast_q <= clkS;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // bus blocking, selects and logic inputs

  logic        down_d;
  logic        pd_q;
  logic [15:0] busAddr_q;
  logic [15:0] busAddr_d;
  logic [7:0]  busData_q;
  logic [7:0]  busData_d;
  logic        memSel_d;
  logic        flash_q;
  logic        sram_q;
  logic        io_q;
  logic [5:0]  pld_q;
  logic [5:0]  pld_d;

  always_comb
  begin
    down_d    = (state_d == APD_DOWN);
    busAddr_d = down_d ? busAddr_q : busS[`APD_BUS_W-1:`APD_ADDR_LSB]; // R6
    busData_d = down_d ? busData_q : busS[`APD_ADDR_LSB-1:0]; // R6
    memSel_d  = !csnS && !down_d; // R6 R13
    // chip select plays no part in what reaches the logic
    pld_d[0]  = regB_q[`APD_REGB_WR]   ? 1'b1 : wrS; // R10 R14 R19
    pld_d[1]  = regB_q[`APD_REGB_RD]   ? 1'b1 : rdS; // R10 R19
    pld_d[2]  = regB_q[`APD_REGB_PSEN] ? 1'b1 : psenS; // R10 R19
    pld_d[3]  = regB_q[`APD_REGB_ALE]  ? 1'b0 : aleS; // R10 R19
    pld_d[4]  = regA_q[`APD_REGA_ARRAY_CLK] ? 1'b0 : clkS; // R7 R15
    pld_d[5]  = regA_q[`APD_REGA_MCELL_CLK] ? 1'b0 : clkS; // R7 R15
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      pd_q      <= 1'b0;
      busAddr_q <= `APD_ADDR_RST;
      busData_q <= `APD_DATA_RST;
      flash_q   <= 1'b0;
      sram_q    <= 1'b0;
      io_q      <= 1'b0;
      pld_q     <= `APD_PLD_RST;
    end
    else
    begin
      pd_q      <= down_d;
      busAddr_q <= busAddr_d;
      busData_q <= busData_d;
      flash_q   <= memSel_d;
      sram_q    <= memSel_d;
      io_q      <= memSel_d;
      pld_q     <= pld_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // port pins

  logic [`APD_NUM_PINS-1:0] portOut_q;
  logic [`APD_NUM_PINS-1:0] portOe_q;

  genvar gi;
  generate
    for (gi = 0; gi < `APD_NUM_PINS; gi++)
    begin : g_pin
      logic           out_d;
      logic           oe_d;
      apd_port_func_t func;
      assign func = apd_port_func_t'(portFunc[gi*`APD_FUNC_W +: `APD_FUNC_W]);
      always_comb
      begin
        out_d = portOut_q[gi];
        oe_d  = portOe_q[gi];
        case (func)
          APD_PF_MCU_IO:
          begin
            out_d = down_d ? portOut_q[gi] : portDataOut[gi]; // R9
            oe_d  = down_d ? portOe_q[gi]  : portDirOut[gi]; // R9
          end
          APD_PF_PLD_OUT:
          begin
            out_d = pldOut[gi]; // R8
            oe_d  = pldOe[gi]; // R8
          end
          APD_PF_ADDR_OUT:
          begin
            // undefined level; zero is the cheapest choice
            out_d = down_d ? 1'b0 : busS[`APD_ADDR_LSB+gi]; // R9
            oe_d  = 1'b1;
          end
          default:
          begin
            out_d = busS[gi];
            oe_d  = down_d ? 1'b0 : portDirOut[gi]; // R9
          end
        endcase
      end
      always_ff @(posedge clk or negedge nrst)
      begin
        if (!nrst)
        begin
          portOut_q[gi] <= 1'b0;
          portOe_q[gi]  <= 1'b0;
        end
        else
        begin
          portOut_q[gi] <= out_d;
          portOe_q[gi]  <= oe_d;
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // outputs

  assign power_down_out        = pd_q;
  assign busAddr               = busAddr_q;
  assign busData               = busData_q;
  assign flashSelect           = flash_q;
  assign sramSelect            = sram_q;
  assign ioRegisterBlockSelect = io_q;
  assign {pldMcellClk, pldArrayClk, pldAle, pldPsenN, pldRdN, pldWrN} = pld_q;
  assign turboOff              = regA_q[`APD_REGA_TURBO]; // R11 R12
  assign power_mode_reg_a      = regA_q;
  assign power_mode_reg_b      = regB_q;
  assign idleCount             = cnt_q;
  assign portOut               = portOut_q;
  assign portOe                = portOe_q;

  ////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  a_entry_at_limit: assert property ( // R2
    state_q == APD_RUN && apdEn && cnt_q == `APD_IDLE_LIMIT && csnS && !aleEdge && !rstS
    |=> power_down_out)
    else $error("power-down not entered at idle limit");

  a_count_disabled: assert property ( // R17
    !apdEn |=> cnt_q == `APD_CNT_ZERO)
    else $error("counter ran while disabled");

  a_strobe_restart: assert property ( // R21
    state_q == APD_RUN && aleEdge |=> cnt_q == `APD_CNT_ZERO && !power_down_out)
    else $error("strobe edge did not restart count");

  a_wake_strobe: assert property ( // R4
    state_q == APD_DOWN && aleEdge |=> !power_down_out)
    else $error("no wake on strobe activity");

  a_wake_select: assert property ( // R5
    state_q == APD_DOWN && (!csnS || rstS) |=> state_q == APD_RUN)
    else $error("no wake on select or reset");

  a_bus_held: assert property ( // R6
    power_down_out && state_d == APD_DOWN |=> $stable(busAddr) && $stable(busData))
    else $error("bus moved while powered down");

  a_mem_deselect: assert property ( // R6
    power_down_out |-> !flashSelect && !sramSelect && !ioRegisterBlockSelect)
    else $error("memory selected in power-down");

  a_select_high: assert property ( // R13
    $past(csnS) |-> !sramSelect && !flashSelect)
    else $error("memory selected with chip select high");

  a_select_free: assert property ( // R14
    !regB_q[`APD_REGB_WR] |=> pldWrN == $past(wrS))
    else $error("write strobe blocked without blocking bit");

  a_count_masked: assert property ( // R7
    state_q == APD_RUN && apdEn && regA_q[`APD_REGA_ARRAY_CLK] && clkRise && !aleEdge && !rstS
    && cnt_q != `APD_IDLE_LIMIT |=> cnt_q == 4'($past(cnt_q) + `APD_CNT_ONE))
    else $error("counter stalled by clock masking");

  a_warm_keep: assert property ( // R20
    rstS && !regWrite |=> $stable(regA_q) && $stable(regB_q))
    else $error("mode registers changed on warm reset");

  c_enter_down: cover property (state_q == APD_RUN ##1 state_q == APD_DOWN);
  c_wake_strobe: cover property (state_q == APD_DOWN && aleEdge ##1 state_q == APD_RUN);
  c_wake_select: cover property (state_q == APD_DOWN && !csnS ##1 state_q == APD_RUN);
  c_block_write: cover property (regWrite && regSelect == `APD_SEL_REG_B ##1 regB_q != `APD_REG_RESET);

endmodule : apd_top

// ===== testbench/apd_mcu_model.sv
// far-side model: mcu address strobe and dedicated pin clock
// assumes clk is the bench clock; run inputs come from the bench
module apd_mcu_model
(
  input  wire logic clk,
  input  wire logic nrst,
  input  wire logic pinClkRun,
  input  wire logic strobeRun,
  output logic      addrStrobe,
  output logic      pin_clock_in
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [1:0] divQ;

  ////////////////////////////////////////////////////////////////
  // four clk periods per pin clock: slow enough to be seen, and
  // well under any rated limit with turbo off
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      divQ         <= 2'h0;
      pin_clock_in <= 1'b0;
      addrStrobe   <= 1'b0;
    end
    else
    begin
      divQ <= divQ + 2'h1;
      if (pinClkRun && divQ[0]) pin_clock_in <= !pin_clock_in;
      // strobe idle holds a steady level, either level is legal
      if (strobeRun && divQ[0]) addrStrobe <= !addrStrobe;
    end
  end
endmodule : apd_mcu_model

// ===== testbench/apd_top_tb.sv
// self-checking bench of the auto power-down controller
// assumes apd_top, apd_mcu_model and the shared files are compiled first
`include "apd_regs.svh"
module apd_top_tb;
  import apd_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;

  logic        clk, nrst, chipSelectN, resetIn, mcuWrN, mcuRdN, mcuPsenN;
  logic        regWrite, regSelect, pinClkRun, strobeRun;
  logic [15:0] mcuAddr, portFunc;
  logic [7:0]  mcuData, regWdata, portDataOut, portDirOut, pldOut, pldOe;
  logic        addrStrobe, pin_clock_in, power_down_out, flashSelect, sramSelect;
  logic        ioRegisterBlockSelect, pldWrN, pldRdN, pldPsenN, pldAle;
  logic        pldArrayClk, pldMcellClk, turboOff;
  logic [15:0] busAddr;
  logic [7:0]  busData, power_mode_reg_a, power_mode_reg_b, portOut, portOe;
  logic [3:0]  idleCount;
  int          n_fail, n_checks, cycles;

  ////////////////////////////////////////////////////////////////
  apd_mcu_model mcu (.clk(clk), .nrst(nrst), .pinClkRun(pinClkRun), .strobeRun(strobeRun),
    .addrStrobe(addrStrobe), .pin_clock_in(pin_clock_in));

  apd_top DUT (.clk(clk), .nrst(nrst), .addrStrobe(addrStrobe), .pin_clock_in(pin_clock_in),
    .chipSelectN(chipSelectN), .resetIn(resetIn), .mcuWrN(mcuWrN), .mcuRdN(mcuRdN),
    .mcuPsenN(mcuPsenN), .mcuAddr(mcuAddr), .mcuData(mcuData), .regWrite(regWrite),
    .regSelect(regSelect), .regWdata(regWdata), .portFunc(portFunc), .portDataOut(portDataOut),
    .portDirOut(portDirOut), .pldOut(pldOut), .pldOe(pldOe), .power_down_out(power_down_out),
    .busAddr(busAddr), .busData(busData), .flashSelect(flashSelect), .sramSelect(sramSelect),
    .ioRegisterBlockSelect(ioRegisterBlockSelect), .pldWrN(pldWrN), .pldRdN(pldRdN),
    .pldPsenN(pldPsenN), .pldAle(pldAle), .pldArrayClk(pldArrayClk), .pldMcellClk(pldMcellClk),
    .turboOff(turboOff), .power_mode_reg_a(power_mode_reg_a), .power_mode_reg_b(power_mode_reg_b),
    .idleCount(idleCount), .portOut(portOut), .portOe(portOe));

  ////////////////////////////////////////////////////////////////
  task automatic conclude();
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : conclude

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    n_checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic wrReg(input logic sel, input logic [7:0] d);
    @(posedge clk);
    regWrite  <= 1'b1;
    regSelect <= sel;
    regWdata  <= d;
    @(posedge clk);
    regWrite <= 1'b0;
    @(negedge clk);
  endtask : wrReg

  task automatic idle(input int n);
    repeat (n) @(negedge clk);
  endtask : idle

  // bounded wait for the power-down output, sampled mid-cycle
  task automatic waitPd(input logic v, input int lim);
    int i;
    i = 0;
    while (power_down_out !== v && i < lim)
    begin
      @(negedge clk);
      i++;
    end
    chk("powerDown", {15'h0, v}, {15'h0, power_down_out});
  endtask : waitPd

  task automatic drv(input logic cs, input logic rst, input logic strobe);
    @(posedge clk);
    chipSelectN <= cs;
    resetIn     <= rst;
    strobeRun   <= strobe;
  endtask : drv

  ////////////////////////////////////////////////////////////////
  initial
  begin
    clk = 1'b0;
    forever #10 clk = !clk;
  end

  always @(posedge clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 20000)
    begin
      n_fail++;
      conclude();
    end
  end

  initial
  begin
    {nrst, regWrite, regSelect, regWdata, resetIn, pinClkRun, strobeRun} = '0;
    {chipSelectN, mcuWrN, mcuRdN, mcuPsenN} = 4'hf;
    {mcuAddr, mcuData, pldOut} = {16'h1234, 8'h5a, 8'h00};
    {portFunc, portDataOut, portDirOut, pldOe} = {16'h0093, 8'h02, 8'h02, 8'h04};
    n_fail = 0;
    n_checks = 0;
    cycles = 0;
    repeat (4) @(posedge clk);
    nrst <= 1'b1;
    idle(6);
    chk("regA", 16'h0000, {8'h0, power_mode_reg_a});
    chk("pldWrN", 16'h0001, {15'h0, pldWrN});
    chk("busAddr", 16'h1234, busAddr);
    // disabled: pin clock runs, counter stays put
    @(posedge clk) pinClkRun <= 1'b1;
    idle(90);
    chk("idleDisabled", 16'h0000, {12'h0, idleCount});
    chk("pdDisabled", 16'h0000, {15'h0, power_down_out});
    // masks and blocking bits; clocks masked away from logic only
    wrReg(`APD_SEL_REG_B, 8'hff);
    @(posedge clk) {mcuWrN, mcuRdN, mcuPsenN} <= 3'b000;
    wrReg(`APD_SEL_REG_A, 8'hff);
    chk("regA", {8'h0, `APD_REGA_MASK}, {8'h0, power_mode_reg_a});
    chk("regB", {8'h0, `APD_REGB_MASK}, {8'h0, power_mode_reg_b});
    idle(4);
    chk("turboOff", 16'h0001, {15'h0, turboOff});
    chk("arrayClk", 16'h0000, {14'h0, pldArrayClk, pldMcellClk});
    chk("blockedStrobes", 16'h000e, {12'h0, pldWrN, pldRdN, pldPsenN, pldAle});
    // fifteen idle periods with the clock masked raise power-down
    waitPd(1'b1, 100);
    chk("idleSat", 16'h000f, {12'h0, idleCount});
    chk("selects", 16'h0000, {13'h0, flashSelect, sramSelect, ioRegisterBlockSelect});
    @(posedge clk)
    begin
      mcuAddr     <= 16'habcd;
      mcuData     <= 8'ha4;
      portDataOut <= 8'h00;
      pldOut      <= 8'h04;
    end
    idle(6);
    chk("busFrozen", 16'h1234, busAddr);
    chk("busDataFrozen", 16'h005a, {8'h0, busData});
    chk("portOut", 16'h0006, {12'h0, portOut[3:0]});
    chk("portOe", 16'h000e, {12'h0, portOe[3:0]});
    // wake by strobe activity
    drv(1'b1, 1'b0, 1'b1);
    waitPd(1'b0, 10);
    idle(20);
    chk("idleToggling", 16'h0000, {12'h0, idleCount});
    chk("busFollows", 16'habcd, busAddr);
    chk("busDataFollows", 16'h00a4, {8'h0, busData});
    chk("addrOutPin", 16'h0001, {15'h0, portOut[3]});
    // wake by chip select low; then chip select high leaves logic inputs alone
    wrReg(`APD_SEL_REG_B, 8'h00);
    drv(1'b1, 1'b0, 1'b0);
    waitPd(1'b1, 100);
    drv(1'b0, 1'b0, 1'b0);
    waitPd(1'b0, 10);
    idle(4);
    chk("selectsCsLow", 16'h0007, {13'h0, flashSelect, sramSelect, ioRegisterBlockSelect});
    chk("pldPsenNFree", 16'h0000, {15'h0, pldPsenN});
    @(posedge clk)
    begin
      chipSelectN <= 1'b1;
      mcuWrN      <= 1'b1;
    end
    idle(5);
    chk("selectsCsHigh", 16'h0000, {13'h0, flashSelect, sramSelect, ioRegisterBlockSelect});
    chk("pldWrNCsHigh", 16'h0001, {15'h0, pldWrN});
    @(posedge clk) mcuWrN <= 1'b0;
    idle(5);
    chk("pldWrNCsHigh", 16'h0000, {15'h0, pldWrN});
    // wake by reset pin; mode register a survives it
    waitPd(1'b1, 100);
    drv(1'b1, 1'b1, 1'b0);
    waitPd(1'b0, 10);
    chk("regAKept", {8'h0, `APD_REGA_MASK}, {8'h0, power_mode_reg_a});
    drv(1'b1, 1'b0, 1'b0);
    idle(10);
    // power-up reset in mid-run clears both mode registers
    @(posedge clk) nrst <= 1'b0;
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    idle(6);
    chk("regAPowerUp", 16'h0000, {8'h0, power_mode_reg_a});
    chk("regBPowerUp", 16'h0000, {8'h0, power_mode_reg_b});
    conclude();
  end
endmodule : apd_top_tb
